// file: hw/sideband_request_decoder.sv
// sideband request decoder: rebuilds memory requests from 16-bit sideband operations
// assumes: linkClk is the tick clock of the sideband port (one byte per rising edge, high
// half first); core-side control inputs are synchronous to core_clk
//
// Summary of operation
// - idle is all ones; one byte at 1x, a full pair at 2x and 4x.
// - type 1 has opcode 0, carries address 14..3 and length; starts access.
// - address bits 2..0 of a rebuilt request are always zero.
// - type 2 has opcode 10, carries command, reserved bit, address 23..15; stored only.
// - type 3 has opcode 110, carries reserved bit and address 35..24; stored only.
// - with extended addressing off, address 35..32 of type 3 is ignored.
// - type 4 has opcode 1110, carries address 47..36; stored only.
// - only type 1 starts a memory cycle; others just overwrite sticky values.
// - operation types are accepted in any order.
// - type 1 before any sticky load may use unspecified upper address and command.
// - type 1 merges with stored type 2, 3 and enabled type 4 into a request.
// - address bits 63..48 are always zero.
// - idle patterns leave the sticky values unchanged.
// - 1x operation spans two clocks; 2x one clock; 4x two per clock.
// - all port activity is ignored until decoding is enabled.
// - with extended addressing off, type 4 is unused and address 47..32 is zero.
// - at 2x the high half comes first, the low half second.
`timescale 1ns/100ps
`default_nettype none
module sideband_request_decoder (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // core-side configuration
  input wire logic decodeEnable,
  input wire logic extAddrEnable,
  input wire sideband_request_pkg::rate_t transferRate,
  // sideband link
  input wire logic linkClk,
  input wire logic [sideband_request_pkg::SB_W-1:0] sideband_request_port,
  // rebuilt memory request
  output logic reqValid,
  output logic [sideband_request_pkg::ADDR_W-1:0] reqAddr,
  output logic [sideband_request_pkg::CMD_W-1:0] reqCommand,
  output logic [sideband_request_pkg::LEN_W-1:0] reqLength,
  // status
  output logic reservedSeen,
  output logic stickyLoaded
);
  import sideband_request_pkg::*;

  // link domain
  logic linkRstMeta_r;
  logic linkRstB_r;
  logic enMeta_r;
  logic enSync_r;
  logic extMeta_r;
  logic extSync_r;
  logic [1:0] rateMeta_r;
  logic [1:0] rateSync_r;
  logic [SB_W-1:0] sbByte_r;
  logic [SB_W-1:0] hiByte_r;
  link_state_t state_r;
  link_state_t state_nxt;
  logic [CMD_W-1:0] t2Cmd_r;
  logic [T2_ADDR_W-1:0] t2Addr_r;
  logic [T3_ADDR_W-1:0] t3Addr_r;
  logic [T4_ADDR_W-1:0] t4Addr_r;
  logic [1:0] loaded_r;
  logic [ADDR_W-1:0] holdAddr_r;
  logic [CMD_W-1:0] holdCmd_r;
  logic [LEN_W-1:0] holdLen_r;
  logic reqToggle_r;
  logic resToggle_r;

  // link-side reset release follows linkClk
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRstMeta_r <= 1'b0;
      linkRstB_r <= 1'b0;
    end else begin
      linkRstMeta_r <= 1'b1;
      linkRstB_r <= linkRstMeta_r;
    end
  end

  // decode enable crosses into the link domain
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      enMeta_r <= 1'b0;
      enSync_r <= 1'b0;
    end else begin
      enMeta_r <= decodeEnable;
      enSync_r <= enMeta_r;
    end
  end

  // extended-address enable crosses into the link domain
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      extMeta_r <= 1'b0;
      extSync_r <= 1'b0;
    end else begin
      extMeta_r <= extAddrEnable;
      extSync_r <= extMeta_r;
    end
  end

  // rate selection crosses into the link domain; change it only while idle
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      rateMeta_r <= RATE_1X;
      rateSync_r <= RATE_1X;
    end else begin
      rateMeta_r <= transferRate;
      rateSync_r <= rateMeta_r;
    end
  end

  wire logic enabled = enSync_r & linkRstB_r;
  wire logic rateIs1x = (rateSync_r == RATE_1X);
  wire logic byteIsIdle = (sbByte_r == IDLE_BYTE);

  // decode of a completed pair: high byte held, low byte on the port register
  wire logic isT1 = (hiByte_r[SB_W-1] == OP_T1);
  wire logic isT2 = (hiByte_r[SB_W-1 -: 2] == OP_T2);
  wire logic isT3 = (hiByte_r[SB_W-1 -: 3] == OP_T3);
  wire logic isT4 = (hiByte_r[SB_W-1 -: 4] == OP_T4);
  wire logic isReserved = (hiByte_r[SB_W-1 -: 4] == RESERVED_HI) && (hiByte_r != IDLE_BYTE);
  wire logic pairDone = (state_r == LK_LOW) && enabled;
  wire logic takeT1 = pairDone && isT1;
  wire logic takeT2 = pairDone && isT2;
  wire logic takeT3 = pairDone && isT3;
  wire logic takeT4 = pairDone && isT4 && extSync_r;

  // merged request; low three address bits never travel on the port
  wire logic [3:0] upper35 = extSync_r ? t3Addr_r[T3_ADDR_W-1 -: 4] : EXT35_ZERO;
  wire logic [T4_ADDR_W-1:0] upper47 = extSync_r ? t4Addr_r : EXT47_ZERO;
  wire logic [ADDR_W-1:0] mergedAddr = {UPPER_ZERO,
                                        upper47,
                                        upper35,
                                        t3Addr_r[T3_ADDR_W-5:0],
                                        t2Addr_r,
                                        hiByte_r[T1_HI_MSB:0],
                                        sbByte_r[T1_LO_ADDR_MSB:T1_LO_ADDR_LSB],
                                        LOW_ADDR_ZERO};

  // byte framing: high byte first, idle is a single tick only at 1x
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LK_HIGH: begin
        if (!enabled) begin
          state_nxt = LK_HIGH;
        end else if (byteIsIdle && rateIs1x) begin
          state_nxt = LK_HIGH;
        end else begin
          state_nxt = LK_LOW;
        end
      end
      LK_LOW: begin
        state_nxt = LK_HIGH;
      end
      default: begin
        state_nxt = LK_HIGH;
      end
    endcase
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      sbByte_r <= BYTE_RESET;
    end else begin
      sbByte_r <= sideband_request_port;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= LK_HIGH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // high byte is held while the low byte arrives
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      hiByte_r <= BYTE_RESET;
    end else if (state_r == LK_HIGH) begin
      hiByte_r <= sbByte_r;
    end
  end

  // sticky values change only on their own operation type; idles touch nothing
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      t2Cmd_r <= CMD_RESET;
      t2Addr_r <= '0;
    end else if (takeT2) begin
      t2Cmd_r <= hiByte_r[T2_CMD_MSB:T2_CMD_LSB];
      t2Addr_r <= {sbByte_r, hiByte_r[T2_A15_BIT]};
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      t3Addr_r <= '0;
    end else if (takeT3) begin
      t3Addr_r <= {hiByte_r[T34_HI_MSB:0], sbByte_r};
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      t4Addr_r <= '0;
    end else if (takeT4) begin
      t4Addr_r <= {sbByte_r, hiByte_r[T34_HI_MSB:0]};
    end
  end

  // remembers which of the type 2 and type 3 parts were loaded since reset
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_r <= 2'h0;
    end else begin
      if (takeT2) begin
        loaded_r[0] <= 1'b1;
      end
      if (takeT3) begin
        loaded_r[1] <= 1'b1;
      end
    end
  end

  // a type 1 snapshots the merged request
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      holdAddr_r <= ADDR_RESET;
      holdCmd_r <= CMD_RESET;
      holdLen_r <= '0;
    end else if (takeT1) begin
      holdAddr_r <= mergedAddr;
      holdCmd_r <= t2Cmd_r;
      holdLen_r <= sbByte_r[T1_LEN_MSB:0];
    end
  end

  // each request and each reserved pair flips a toggle for the core side
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      reqToggle_r <= 1'b0;
    end else if (takeT1) begin
      reqToggle_r <= ~reqToggle_r;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      resToggle_r <= 1'b0;
    end else if (pairDone && isReserved) begin
      resToggle_r <= ~resToggle_r;
    end
  end

  // core domain
  logic reqMeta_r;
  logic reqSync_r;
  logic reqSeen_r;
  logic resMeta_r;
  logic resSync_r;
  logic resSeen_r;
  logic loadMeta_r;
  logic loadSync_r;
  logic reqValid_r;
  logic [ADDR_W-1:0] reqAddr_r;
  logic [CMD_W-1:0] reqCommand_r;
  logic [LEN_W-1:0] reqLength_r;
  logic reservedSeen_r;

  wire logic allLoaded = loaded_r[0] & loaded_r[1];
  wire logic newReq = reqSync_r ^ reqSeen_r;
  wire logic newRes = resSync_r ^ resSeen_r;

  // request toggle: two flops to synchronise, a third to find its edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqMeta_r <= 1'b0;
      reqSync_r <= 1'b0;
      reqSeen_r <= 1'b0;
    end else begin
      reqMeta_r <= reqToggle_r;
      reqSync_r <= reqMeta_r;
      reqSeen_r <= reqSync_r;
    end
  end

  // reserved-pair toggle, same structure
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resMeta_r <= 1'b0;
      resSync_r <= 1'b0;
      resSeen_r <= 1'b0;
    end else begin
      resMeta_r <= resToggle_r;
      resSync_r <= resMeta_r;
      resSeen_r <= resSync_r;
    end
  end

  // loaded level only ever rises, so two flops suffice
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loadMeta_r <= 1'b0;
      loadSync_r <= 1'b0;
    end else begin
      loadMeta_r <= allLoaded;
      loadSync_r <= loadMeta_r;
    end
  end

  // one-cycle pulses on each toggle edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqValid_r <= 1'b0;
      reservedSeen_r <= 1'b0;
    end else begin
      reqValid_r <= newReq;
      reservedSeen_r <= newRes;
    end
  end

  // held link data is stable for at least two link ticks after the toggle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqAddr_r <= ADDR_RESET;
      reqCommand_r <= CMD_RESET;
      reqLength_r <= '0;
    end else if (newReq) begin
      reqAddr_r <= holdAddr_r;
      reqCommand_r <= holdCmd_r;
      reqLength_r <= holdLen_r;
    end
  end

  assign reqValid = reqValid_r;
  assign reqAddr = reqAddr_r;
  assign reqCommand = reqCommand_r;
  assign reqLength = reqLength_r;
  assign reservedSeen = reservedSeen_r;
  assign stickyLoaded = loadSync_r;
endmodule : sideband_request_decoder
`default_nettype wire

// file: hw/sideband_request_pkg.sv
// constants for the sideband request decoder: encodings, field positions, reset values
// assumes: imported by the decoder, its checker and the bench, SystemVerilog-2012 tools
package sideband_request_pkg;
  localparam int SB_W = 8;
  localparam int ADDR_W = 64;
  localparam int CMD_W = 4;
  localparam int LEN_W = 3;
  localparam int T2_ADDR_W = 9;
  localparam int T3_ADDR_W = 12;
  localparam int T4_ADDR_W = 12;

  // idle byte and reserved upper nibble
  localparam logic [SB_W-1:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] RESERVED_HI = 4'hF;

  // opcode prefixes in the high byte
  localparam logic OP_T1 = 1'b0;
  localparam logic [1:0] OP_T2 = 2'h2;
  localparam logic [2:0] OP_T3 = 3'h6;
  localparam logic [3:0] OP_T4 = 4'hE;

  // field positions inside the high byte
  localparam int T1_HI_MSB = 6;
  localparam int T2_CMD_MSB = 5;
  localparam int T2_CMD_LSB = 2;
  localparam int T2_A15_BIT = 0;
  localparam int T34_HI_MSB = 3;
  // field positions inside the low byte
  localparam int T1_LO_ADDR_MSB = 7;
  localparam int T1_LO_ADDR_LSB = 3;
  localparam int T1_LEN_MSB = 2;

  // fixed-zero address pieces
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [2:0] LOW_ADDR_ZERO = 3'h0;
  localparam logic [3:0] EXT35_ZERO = 4'h0;
  localparam logic [11:0] EXT47_ZERO = 12'h000;

  // reset values
  localparam logic [CMD_W-1:0] CMD_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [SB_W-1:0] BYTE_RESET = 8'hFF;

  typedef enum logic [1:0] {
    RATE_1X = 2'h0,
    RATE_2X = 2'h1,
    RATE_4X = 2'h2
  } rate_t;

  typedef enum logic [1:0] {
    LK_HIGH = 2'b01,
    LK_LOW = 2'b10
  } link_state_t;
endpackage : sideband_request_pkg

// file: test/sideband_master_model.sv
// master model: sends queued 16-bit operations high byte first, idle bytes otherwise
// assumes: linkClk is the byte tick clock; bench queues the operations
`timescale 1ns/100ps
`default_nettype none
module sideband_master_model (
  // link clock, reset and paired-mode flag
  input wire logic linkClk,
  input wire logic rst_b,
  input wire logic pairedMode,
  // byte toward the decoder
  output logic [7:0] sbByte
);
  logic [15:0] opQ[$];
  logic [7:0] loHold;
  logic loNext;
  logic phase;
  logic pairedSeen;
  logic loSlot;
  task automatic push(input logic [15:0] op);
    opQ.push_back(op);
  endtask : push
  // once paired mode is seen, the byte driven now is taken as a high byte
  always @(posedge linkClk) begin
    loSlot = (pairedMode && !pairedSeen) ? 1'b0 : phase;
    pairedSeen <= pairedMode;
    phase <= ~loSlot;
    if (!rst_b) begin
      sbByte <= 8'hFF;
      loNext <= 1'b0;
    end else if (loNext) begin
      sbByte <= loHold;
      loNext <= 1'b0;
    end else if (opQ.size() != 0 && !(pairedMode && loSlot)) begin
      sbByte <= opQ[0][15:8];
      loHold <= opQ[0][7:0];
      void'(opQ.pop_front());
      loNext <= 1'b1;
    end else begin
      sbByte <= 8'hFF;
    end
  end
endmodule : sideband_master_model
`default_nettype wire

// file: test/sideband_request_decoder_tb.sv
// self-checking bench for the decoder, master model on the link side
// assumes: design and checker compiled first; link clock unrelated to core clock
`timescale 1ns/100ps
`default_nettype none
module sideband_request_decoder_tb;
  import sideband_request_pkg::*;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b;
  logic decodeEnable;
  logic extAddrEnable;
  rate_t transferRate;
  logic [7:0] sbByte;
  logic reqValid;
  logic reservedSeen;
  logic stickyLoaded;
  wire logic pairedMode = (transferRate != RATE_1X);
  logic [63:0] reqAddr, lastAddr;
  logic [3:0] reqCommand, lastCmd;
  logic [2:0] reqLength, lastLen;
  int reqCount = 0, resCount = 0, err_count = 0, comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  always #6 linkClk = ~linkClk;
  sideband_master_model m (.linkClk(linkClk), .rst_b(rst_b),
    .pairedMode(pairedMode), .sbByte(sbByte));
  sideband_request_decoder DUT (.core_clk(core_clk), .rst_b(rst_b),
    .decodeEnable(decodeEnable), .extAddrEnable(extAddrEnable), .transferRate(transferRate),
    .linkClk(linkClk), .sideband_request_port(sbByte), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqCommand(reqCommand), .reqLength(reqLength),
    .reservedSeen(reservedSeen), .stickyLoaded(stickyLoaded));
  always @(negedge core_clk) begin
    if (reqValid === 1'b1) begin
      reqCount <= reqCount + 1;
      lastAddr <= reqAddr;
      lastCmd <= reqCommand;
      lastLen <= reqLength;
    end
    if (reservedSeen === 1'b1) resCount <= resCount + 1;
  end
  task automatic give_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic cfg(input logic de, input logic ext, input rate_t r);
    @(posedge core_clk);
    decodeEnable <= de;
    extAddrEnable <= ext;
    transferRate <= r;
    repeat (20) @(posedge core_clk);
  endtask : cfg
  task automatic await(input int k);
    int n;
    n = 0;
    while ((m.opQ.size() != 0 || reqCount < k) && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    repeat (20) @(negedge core_clk);
    if (n == 300) begin
      err_count++;
      give_verdict();
    end
  endtask : await
  task automatic exp(input int k, input logic [63:0] a, input logic [3:0] c,
                     input logic [2:0] l);
    await(k);
    check(reqCount == k && lastAddr === a && lastCmd === c && lastLen === l, "request");
  endtask : exp
  task automatic sc_merge();
    int n0;
    n0 = reqCount;
    m.push(16'h9DA5);
    m.push(16'hC03C);
    await(n0);
    check(reqCount == n0 && stickyLoaded === 1'b1, "sticky load");
    m.push(16'h559D);
    exp(n0 + 1, 64'h0000_0000_3CA5_D598, 4'h7, 3'h5);
  endtask : sc_merge
  task automatic sc_ext();
    cfg(1'b1, 1'b1, RATE_1X);
    m.push(16'hCB3C);
    m.push(16'hE96E);
    m.push(16'h010A);
    exp(reqCount + 1, 64'h0000_6E9B_3CA5_8108, 4'h7, 3'h2);
    cfg(1'b1, 1'b0, RATE_1X);
    m.push(16'h010A);
    exp(reqCount + 1, 64'h0000_0000_3CA5_8108, 4'h7, 3'h2);
  endtask : sc_ext
  task automatic sc_order();
    m.push(16'h010A);
    m.push(16'h559D);
    exp(reqCount + 2, 64'h0000_0000_3CA5_D598, 4'h7, 3'h5);
    m.push(16'h9811);
    m.push(16'h559D);
    exp(reqCount + 1, 64'h0000_0000_3C11_5598, 4'h6, 3'h5);
  endtask : sc_order
  task automatic sc_reserved();
    int n0, r0;
    n0 = reqCount;
    r0 = resCount;
    m.push(16'hF012);
    await(n0);
    check(resCount == r0 + 1 && reqCount == n0, "reserved pair");
    m.push(16'h559D);
    exp(n0 + 1, 64'h0000_0000_3C11_5598, 4'h6, 3'h5);
  endtask : sc_reserved
  task automatic sc_disabled();
    int n0;
    cfg(1'b0, 1'b0, RATE_1X);
    n0 = reqCount;
    m.push(16'h9DA5);
    m.push(16'h559D);
    await(n0);
    check(reqCount == n0, "decode disabled");
    cfg(1'b1, 1'b0, RATE_1X);
    m.push(16'h559D);
    exp(n0 + 1, 64'h0000_0000_3C11_5598, 4'h6, 3'h5);
  endtask : sc_disabled
  task automatic sc_rates();
    rate_t rates[2];
    rates = '{RATE_2X, RATE_4X};
    foreach (rates[i]) begin
      cfg(1'b1, 1'b0, rates[i]);
      m.push(16'h010A);
      exp(reqCount + 1, 64'h0000_0000_3C11_0108, 4'h6, 3'h2);
    end
    cfg(1'b1, 1'b0, RATE_1X);
  endtask : sc_rates
  initial begin
    rst_b = 1'b0;
    decodeEnable = 1'b0;
    extAddrEnable = 1'b0;
    transferRate = RATE_1X;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    cfg(1'b1, 1'b0, RATE_1X);
    sc_merge();
    sc_ext();
    sc_order();
    sc_reserved();
    sc_disabled();
    sc_rates();
    give_verdict();
  end
endmodule : sideband_request_decoder_tb
`default_nettype wire

// file: test/sideband_request_properties.sv
// assertions on the rebuilt request and status outputs of the decoder
// assumes: bound to the decoder; config levels held steady around traffic
`timescale 1ns/100ps
`default_nettype none
module sideband_request_checker (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // configuration
  input wire logic decodeEnable,
  input wire logic extAddrEnable,
  // request and status
  input wire logic reqValid,
  input wire logic [sideband_request_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [sideband_request_pkg::CMD_W-1:0] reqCommand,
  input wire logic [sideband_request_pkg::LEN_W-1:0] reqLength,
  input wire logic reservedSeen,
  input wire logic stickyLoaded
);
  import sideband_request_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence extOffLong;
    (!extAddrEnable)[*8];
  endsequence
  sequence decodeOffLong;
    (!decodeEnable)[*8];
  endsequence
  upper_zero_a: assert property (reqValid |-> reqAddr[63:48] == UPPER_ZERO)
    else $error("address bits 63..48 not zero");
  low_zero_a: assert property (reqValid |-> reqAddr[2:0] == LOW_ADDR_ZERO)
    else $error("address bits 2..0 not zero");
  pulse_gap_a: assert property (reqValid |=> !reqValid [*3])
    else $error("request pulses too close");
  fields_hold_a: assert property (($changed(reqAddr) || $changed(reqCommand)
    || $changed(reqLength)) |-> reqValid) else $error("request fields moved without request");
  ext_off_zero_a: assert property (extOffLong ##0 reqValid |->
    reqAddr[47:32] == {EXT47_ZERO, EXT35_ZERO}) else $error("extended bits not zero");
  decode_off_a: assert property (decodeOffLong |-> !reqValid)
    else $error("request while decoding disabled");
  reserved_quiet_a: assert property (reservedSeen |-> !reqValid)
    else $error("request on reserved pair");
  sticky_kept_a: assert property (stickyLoaded |=> stickyLoaded)
    else $error("sticky state lost");
endmodule : sideband_request_checker
bind sideband_request_decoder sideband_request_checker chk (.core_clk(core_clk),
  .rst_b(rst_b), .decodeEnable(decodeEnable), .extAddrEnable(extAddrEnable),
  .reqValid(reqValid), .reqAddr(reqAddr), .reqCommand(reqCommand), .reqLength(reqLength),
  .reservedSeen(reservedSeen), .stickyLoaded(stickyLoaded));
`default_nettype wire
